// File: logic/gpm_pkg.sv
// gpm_pkg: register map, field layout and types of the gpio port block.
// assumes one system clock; offsets are apb byte addresses.
package gpm_pkg;
	localparam int unsigned GPM_PINS     = 15;
	localparam int unsigned GPM_FN_W     = 3;
	localparam int unsigned GPM_FN_STRIDE = 4;
	localparam int unsigned GPM_SEL_W    = 8;
	localparam int unsigned GPM_ADDR_W   = 12;
	localparam int unsigned GPM_LOW_PINS = 8;

	localparam logic [11:0] GPM_OFF_DATA  = 12'h000;
	localparam logic [11:0] GPM_OFF_DIR   = 12'h004;
	localparam logic [11:0] GPM_OFF_PULL  = 12'h008;
	localparam logic [11:0] GPM_OFF_DRIVE = 12'h00c;
	localparam logic [11:0] GPM_OFF_SENSE = 12'h010;
	localparam logic [11:0] GPM_OFF_BOTH  = 12'h014;
	localparam logic [11:0] GPM_OFF_POL   = 12'h018;
	localparam logic [11:0] GPM_OFF_MASK  = 12'h01c;
	localparam logic [11:0] GPM_OFF_MSTAT = 12'h024;
	localparam logic [11:0] GPM_OFF_ICLR  = 12'h028;
	localparam logic [11:0] GPM_OFF_FNLO  = 12'h02c;
	localparam logic [11:0] GPM_OFF_FNHI  = 12'h030;
	localparam logic [11:0] GPM_OFF_SET   = 12'h03c;
	localparam logic [11:0] GPM_OFF_CLR   = 12'h040;
	localparam logic [11:0] GPM_OFF_ROUTE = 12'h044;
	localparam logic [11:0] GPM_OFF_RAW   = 12'h020;

	localparam logic [31:0] GPM_RST_ZERO  = 32'h0000_0000;
	localparam logic [31:0] GPM_RST_PULL  = 32'h003f_ffff;
	localparam logic [31:0] GPM_RST_FNHI  = 32'h0000_0110;
	localparam logic [31:0] GPM_FNLO_MASK = 32'h7777_7777;
	localparam logic [31:0] GPM_FNHI_MASK = 32'h0777_7777;

	typedef enum logic [2:0] {
		GPM_FN_GPIO   = 3'b000,
		GPM_FN_FIRST  = 3'b001,
		GPM_FN_SECOND = 3'b100,
		GPM_FN_THIRD  = 3'b101
	} gpm_fn_e;

	typedef enum logic [0:0] {
		GPM_APB_SETUP  = 1'b0,
		GPM_APB_ACCESS = 1'b1
	} gpm_apb_e;

	// per pin alternate peripheral signals, one bit per pin each
	typedef struct packed {
		logic [14:0] out;
		logic [14:0] oe;
	} gpm_alt_s;

	typedef struct packed {
		logic [14:0] out;
		logic [14:0] oe;
		logic [14:0] pull;
		logic [14:0] drive;
	} gpm_pad_s;
endpackage

// File: logic/gpm_port.sv
// gpm_port: fifteen pin gpio port with function mux, pin interrupts and
// timer capture routing, reached as an apb slave.
// assumes pads outside resolve out/oe into the wire and return the level.
`timescale 1ns/10ps

module gpm_port
	import gpm_pkg::*;
#(
	parameter int unsigned PINS = GPM_PINS
) (
	// clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  reset_in,
	// apb slave
	input  wire logic                  psel_in,
	input  wire logic                  penable_in,
	input  wire logic                  pwrite_in,
	input  wire logic [GPM_ADDR_W-1:0] paddr_in,
	input  wire logic [31:0]           pwdata_in,
	input  wire logic [3:0]            pstrb_in,
	output logic      [31:0]           prdata_out,
	output logic                       pready_out,
	output logic                       pslverr_out,
	// pins
	input  wire logic [PINS-1:0]       pin_level_in,
	output gpm_pad_s                   pad_out,
	// alternate peripheral sides
	input  wire gpm_alt_s              first_alt_in,
	input  wire gpm_alt_s              second_alt_in,
	input  wire gpm_alt_s              third_alt_in,
	// timer capture inputs and interrupt
	output logic                       timer1_cap_a_out,
	output logic                       timer1_cap_b_out,
	output logic                       timer2_cap_a_out,
	output logic                       timer2_cap_b_out,
	output logic                       irq_out
);

	////////////////////////////////////////////////////////////////////////
	// registers

	logic [PINS-1:0] data_reg;
	logic [PINS-1:0] dir_reg;
	logic [PINS-1:0] pull_reg;
	logic [PINS-1:0] drive_reg;
	logic [PINS-1:0] sense_reg;
	logic [PINS-1:0] both_reg;
	logic [PINS-1:0] pol_reg;
	logic [PINS-1:0] mask_reg;
	logic [PINS-1:0] raw_reg;
	logic [31:0]     fnlo_reg;
	logic [31:0]     fnhi_reg;
	logic [31:0]     route_reg;
	logic [PINS-1:0] sync1_reg;
	logic [PINS-1:0] sync2_reg;
	logic [PINS-1:0] prev_reg;
	logic            t1a_reg;
	logic            t1b_reg;
	logic            t2a_reg;
	logic            t2b_reg;
	logic            irq_reg;
	logic [31:0]     rdata_reg;

	logic            wr_en;
	logic            rd_setup;
	logic [31:0]     wdata;
	logic [31:0]     rdata_next;
	logic            addr_ok;
	logic [PINS-1:0] hit;
	logic [PINS-1:0] is_gpio;
	logic [PINS-1:0] icl_bits;

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [2:0] fn_of(input logic [31:0] lo,
		input logic [31:0] hi, input int unsigned idx);
		int unsigned pos;
		pos = (idx % GPM_LOW_PINS) * GPM_FN_STRIDE;
		if (idx < GPM_LOW_PINS) begin
			fn_of = lo[pos +: GPM_FN_W];
		end else begin
			fn_of = hi[pos +: GPM_FN_W];
		end
	endfunction

	// out of range index picks nothing rather than aliasing a pin
	function automatic logic pick(input logic [PINS-1:0] lv,
		input logic [31:0] rt, input int unsigned fld);
		logic [GPM_SEL_W-1:0] sel;
		sel  = rt[fld*GPM_SEL_W +: GPM_SEL_W];
		pick = 1'b0;
		for (int i = 0; i < PINS; i++) begin
			if (sel == GPM_SEL_W'(i)) begin
				pick = lv[i];
			end
		end
	endfunction

	// byte lane merge for writes
	function automatic logic [31:0] lanes(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		for (int b = 0; b < 4; b++) begin
			lanes[b*8 +: 8] = st[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// apb: zero wait states, error on unmapped offsets

	always_comb begin
		case (paddr_in)
		GPM_OFF_DATA, GPM_OFF_DIR, GPM_OFF_PULL, GPM_OFF_DRIVE,
		GPM_OFF_SENSE, GPM_OFF_BOTH, GPM_OFF_POL, GPM_OFF_MASK,
		GPM_OFF_RAW, GPM_OFF_MSTAT, GPM_OFF_ICLR, GPM_OFF_FNLO,
		GPM_OFF_FNHI, GPM_OFF_SET, GPM_OFF_CLR, GPM_OFF_ROUTE: begin
			addr_ok = 1'b1;
		end
		default: begin
			addr_ok = 1'b0;
		end
		endcase
	end

	assign wr_en       = psel_in & penable_in & pwrite_in & addr_ok;
	assign rd_setup    = psel_in & ~penable_in & ~pwrite_in;
	// no wait states: every access ends in its first access cycle
	assign pready_out  = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~addr_ok;
	assign prdata_out  = rdata_reg;

	function automatic logic [31:0] pext(input logic [PINS-1:0] v);
		pext = 32'(v);
	endfunction

	function automatic logic [PINS-1:0] pw(input logic [PINS-1:0] old);
		logic [31:0] m;
		m  = lanes(pext(old), pwdata_in, pstrb_in);
		pw = m[PINS-1:0];
	endfunction

	assign wdata = pwdata_in;

	always_comb begin
		case (paddr_in)
		GPM_OFF_DATA:  rdata_next = pext(sync2_reg);
		GPM_OFF_DIR:   rdata_next = pext(dir_reg);
		GPM_OFF_PULL:  rdata_next = pext(pull_reg);
		GPM_OFF_DRIVE: rdata_next = pext(drive_reg);
		GPM_OFF_SENSE: rdata_next = pext(sense_reg);
		GPM_OFF_BOTH:  rdata_next = pext(both_reg);
		GPM_OFF_POL:   rdata_next = pext(pol_reg);
		GPM_OFF_MASK:  rdata_next = pext(mask_reg);
		GPM_OFF_RAW:   rdata_next = pext(raw_reg);
		GPM_OFF_MSTAT: rdata_next = pext(raw_reg & mask_reg);
		GPM_OFF_FNLO:  rdata_next = fnlo_reg;
		GPM_OFF_FNHI:  rdata_next = fnhi_reg;
		GPM_OFF_ROUTE: rdata_next = route_reg;
		default:       rdata_next = GPM_RST_ZERO;
		endcase
	end

	// read data registered in setup so it is stable for the access edge
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rdata_reg <= GPM_RST_ZERO;
		end else if (rd_setup) begin
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output data with atomic set and clear
	// a plain data write wins; set and clear only move bits written 1

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			data_reg <= '0;
		end else if (wr_en && paddr_in == GPM_OFF_DATA) begin
			data_reg <= pw(data_reg);
		end else if (wr_en && paddr_in == GPM_OFF_SET) begin
			data_reg <= data_reg | pw('0);
		end else if (wr_en && paddr_in == GPM_OFF_CLR) begin
			data_reg <= data_reg & ~pw('0);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers
	// pw drops bits above the last pin, so they read back as zero

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			dir_reg   <= '0;
			pull_reg  <= GPM_RST_PULL[PINS-1:0];
			drive_reg <= '0;
			sense_reg <= '0;
			both_reg  <= '0;
			pol_reg   <= '0;
			mask_reg  <= '0;
		end else if (wr_en) begin
			if (paddr_in == GPM_OFF_DIR)   dir_reg   <= pw(dir_reg);
			if (paddr_in == GPM_OFF_PULL)  pull_reg  <= pw(pull_reg);
			if (paddr_in == GPM_OFF_DRIVE) drive_reg <= pw(drive_reg);
			if (paddr_in == GPM_OFF_SENSE) sense_reg <= pw(sense_reg);
			if (paddr_in == GPM_OFF_BOTH)  both_reg  <= pw(both_reg);
			if (paddr_in == GPM_OFF_POL)   pol_reg   <= pw(pol_reg);
			if (paddr_in == GPM_OFF_MASK)  mask_reg  <= pw(mask_reg);
		end
	end

	// reserved bits of the function registers are kept at zero
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			fnlo_reg  <= GPM_RST_ZERO;
			fnhi_reg  <= GPM_RST_FNHI;
			route_reg <= GPM_RST_ZERO;
		end else if (wr_en) begin
			if (paddr_in == GPM_OFF_FNLO) begin
				fnlo_reg <= lanes(fnlo_reg, wdata, pstrb_in)
					& GPM_FNLO_MASK;
			end
			if (paddr_in == GPM_OFF_FNHI) begin
				fnhi_reg <= lanes(fnhi_reg, wdata, pstrb_in)
					& GPM_FNHI_MASK;
			end
			if (paddr_in == GPM_OFF_ROUTE) begin
				route_reg <= lanes(route_reg, wdata, pstrb_in);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin function mux
	// pad controls registered so a function switch cannot glitch a pin

	generate
		for (genvar p = 0; p < PINS; p++) begin : g_pin
			logic [2:0] fn;
			assign fn         = fn_of(fnlo_reg, fnhi_reg, p);
			assign is_gpio[p] = (fn == GPM_FN_GPIO);
			always_ff @(posedge clk_in or posedge reset_in) begin
				if (reset_in) begin
					pad_out.out[p] <= 1'b0;
					pad_out.oe[p]  <= 1'b0;
				end else begin
					case (fn)
					GPM_FN_GPIO: begin
						pad_out.out[p] <= data_reg[p];
						pad_out.oe[p]  <= dir_reg[p];
					end
					GPM_FN_FIRST: begin
						pad_out.out[p] <= first_alt_in.out[p];
						pad_out.oe[p]  <= first_alt_in.oe[p];
					end
					GPM_FN_SECOND: begin
						pad_out.out[p] <= second_alt_in.out[p];
						pad_out.oe[p]  <= second_alt_in.oe[p];
					end
					GPM_FN_THIRD: begin
						pad_out.out[p] <= third_alt_in.out[p];
						pad_out.oe[p]  <= third_alt_in.oe[p];
					end
					default: begin
						pad_out.out[p] <= 1'b0;
						pad_out.oe[p]  <= 1'b0;
					end
					endcase
				end
			end
		end
	endgenerate

	assign pad_out.pull  = pull_reg;
	assign pad_out.drive = drive_reg;

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser and interrupt detection
	// only sync2_reg reads sync1_reg; prev_reg keeps one edge of history

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg  <= '0;
		end else begin
			sync1_reg <= pin_level_in;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			if (sense_reg[i]) begin
				hit[i] = (sync2_reg[i] == pol_reg[i]);
			end else if (both_reg[i]) begin
				hit[i] = (sync2_reg[i] != prev_reg[i]);
			end else begin
				hit[i] = (sync2_reg[i] != prev_reg[i])
					&& (sync2_reg[i] == pol_reg[i]);
			end
		end
	end

	assign icl_bits = (wr_en && paddr_in == GPM_OFF_ICLR)
		? pw('0) : '0;

	// a new event in the clear cycle wins over the clear
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			raw_reg <= '0;
		end else begin
			raw_reg <= (raw_reg & ~icl_bits)
				| (hit & is_gpio);
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(raw_reg & mask_reg);
		end
	end
	// registered so a clear write cannot glitch the request line
	assign irq_out = irq_reg;

	////////////////////////////////////////////////////////////////////////
	// timer capture routing
	// capture follows the synchronised pin, not the raw pad level

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			t1a_reg <= 1'b0;
			t1b_reg <= 1'b0;
			t2a_reg <= 1'b0;
			t2b_reg <= 1'b0;
		end else begin
			t1a_reg <= pick(sync2_reg, route_reg, 0);
			t1b_reg <= pick(sync2_reg, route_reg, 1);
			t2a_reg <= pick(sync2_reg, route_reg, 2);
			t2b_reg <= pick(sync2_reg, route_reg, 3);
		end
	end
	assign timer1_cap_a_out = t1a_reg;
	assign timer1_cap_b_out = t1b_reg;
	assign timer2_cap_a_out = t2a_reg;
	assign timer2_cap_b_out = t2b_reg;

endmodule

// File: tb/gpm_port_props.sv
// gpm_port_props: port level checks of the gpio port.
// assumes route writes use all four byte strobes.
`timescale 1ns/10ps
module gpm_port_props
	import gpm_pkg::*;
#(
	parameter int unsigned PINS = GPM_PINS
) (
	// observed ports
	input wire logic                  clk_in,
	input wire logic                  reset_in,
	input wire logic                  psel_in,
	input wire logic                  penable_in,
	input wire logic                  pwrite_in,
	input wire logic [GPM_ADDR_W-1:0] paddr_in,
	input wire logic [31:0]           pwdata_in,
	input wire logic [3:0]            pstrb_in,
	input wire logic [31:0]           prdata_out,
	input wire logic                  pslverr_out,
	input wire logic [PINS-1:0]       pin_level_in,
	input wire gpm_pad_s              pad_out,
	input wire logic                  timer1_cap_a_out,
	input wire logic                  irq_out
);
	logic            wr;
	logic [31:0]     route_reg;
	logic [2:0]      quiet_reg;
	logic [PINS-1:0] p1_reg, p2_reg, p3_reg;
	assign wr = psel_in & penable_in & pwrite_in;
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	////////////////////////////////////////////////////////////////////////
	// shadow route; capture is trusted only once it has settled
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			route_reg <= 32'h0;
			quiet_reg <= 3'h0;
		end else if (wr && paddr_in == GPM_OFF_ROUTE) begin
			route_reg <= pwdata_in;
			quiet_reg <= 3'h0;
		end else if (quiet_reg != 3'h7) begin
			quiet_reg <= quiet_reg + 3'h1;
		end
	end
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			{p1_reg, p2_reg, p3_reg} <= '0;
		end else begin
			{p1_reg, p2_reg, p3_reg} <= {pin_level_in, p1_reg, p2_reg};
		end
	end
	////////////////////////////////////////////////////////////////////////
	err_access_a:
	assert property (pslverr_out |-> psel_in && penable_in)
		else $error("slave error outside access phase");
	err_unmapped_a:
	assert property (psel_in && penable_in && paddr_in == 12'h048
		|-> pslverr_out) else $error("no error on unmapped address");
	mapped_ok_a:
	assert property (psel_in && penable_in && paddr_in == GPM_OFF_MASK
		|-> !pslverr_out) else $error("error on mapped address");
	rdata_zero_a:
	assert property (psel_in && penable_in && !pwrite_in && pslverr_out
		|-> prdata_out == 32'h0) else $error("unmapped read not zero");
	pull_wr_a:
	assert property (wr && paddr_in == GPM_OFF_PULL && pstrb_in == 4'hf
		|=> pad_out.pull == $past(pwdata_in[14:0]))
		else $error("pull pads do not follow write");
	drive_wr_a:
	assert property (wr && paddr_in == GPM_OFF_DRIVE && pstrb_in == 4'hf
		|-> ##1 pad_out.drive == $past(pwdata_in[14:0]))
		else $error("drive pads do not follow write");
	irq_fall_a:
	assert property ($fell(irq_out) |-> $past(wr) || $past(wr, 2))
		else $error("interrupt dropped without a write");
	cap_route_a:
	assert property (quiet_reg == 3'h7 && route_reg[7:0] < 8'h0f
		|-> timer1_cap_a_out == p3_reg[route_reg[3:0]])
		else $error("capture a not the routed pin");
endmodule
bind gpm_port gpm_port_props #(.PINS(PINS)) gpm_port_props_inst (
	.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
	.pslverr_out(pslverr_out), .pin_level_in(pin_level_in),
	.pad_out(pad_out), .timer1_cap_a_out(timer1_cap_a_out),
	.irq_out(irq_out));

// File: tb/gpm_pin_model.sv
// gpm_pin_model: pads and board around the port, resolving each pin.
// assumes pulls go low except on pins 9 to 11, which pull up.
`timescale 1ns/10ps
module gpm_pin_model
	import gpm_pkg::*;
(
	// pad side and board drivers
	input  wire logic        clk_in,
	input  wire gpm_pad_s    pad_in,
	input  wire logic [14:0] ext_val_in,
	input  wire logic [14:0] ext_en_in,
	// resolved levels
	output logic [14:0]      pin_level_out
);
	logic [14:0] float_reg;
	// a floating pin must never look settled, so it toggles
	always_ff @(posedge clk_in) begin
		float_reg <= (float_reg === 15'h5555) ? 15'h2aaa : 15'h5555;
	end
	always_comb begin
		for (int i = 0; i < 15; i++) begin
			if (pad_in.oe[i]) begin
				pin_level_out[i] = pad_in.out[i];
			end else if (ext_en_in[i]) begin
				pin_level_out[i] = ext_val_in[i];
			end else if (pad_in.pull[i]) begin
				pin_level_out[i] = (i >= 9 && i <= 11);
			end else begin
				pin_level_out[i] = float_reg[i];
			end
		end
	end
endmodule

// File: tb/gpm_port_tb_top.sv
// gpm_port_tb_top: register level tests of the gpio port over apb.
// assumes the pin model resolves pads against the board drivers here.
`timescale 1ns/10ps
module gpm_port_tb_top import gpm_pkg::*;;
	logic        clk_in = 1'b0, reset_in = 1'b1, e;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, q, wv;
	logic        pready, pslverr, irq, t1a, t1b, t2a, t2b;
	logic [14:0] ext_val = 15'h2c35, ext_en = 15'h7fff, pins;
	gpm_pad_s    pad;
	gpm_alt_s    alt1 = '{15'h7fff, 15'h7fff};
	gpm_alt_s    alt2 = '{15'h0, 15'h7fff};
	gpm_alt_s    alt3 = '{15'h5555, 15'h7fff};
	int          failures = 0, n_tests = 0;
	logic [11:0] ra [13] = '{GPM_OFF_MSTAT, GPM_OFF_DIR, GPM_OFF_PULL,
		GPM_OFF_DRIVE, GPM_OFF_SENSE, GPM_OFF_BOTH, GPM_OFF_POL,
		GPM_OFF_MASK, GPM_OFF_FNLO, GPM_OFF_FNHI, GPM_OFF_ROUTE,
		GPM_OFF_SET, GPM_OFF_CLR};
	logic [15:0] rv [13] = '{16'h0, 16'h0, 16'h7fff, 16'h0, 16'h0,
		16'h0, 16'h0, 16'h0, 16'h0, 16'h110, 16'h0, 16'h0, 16'h0};
	logic [31:0] ro [13] = '{32'h0, 32'h7fff, 32'h7fff, 32'h7fff,
		32'h7fff, 32'h7fff, 32'h7fff, 32'h7fff, 32'h7777_7777,
		32'h0777_7777, 32'hffff_ffff, 32'h0, 32'h0};
	logic [2:0]  fc [5] = '{GPM_FN_GPIO, GPM_FN_FIRST, GPM_FN_SECOND,
		GPM_FN_THIRD, 3'b010};
	logic [3:0]  fx [5] = '{4'he, 4'hf, 4'hc, 4'hd, 4'h0};
	// mask, sense, both, polarity; then pending before and after clear
	logic [3:0]  ic [6] = '{4'h8, 4'h9, 4'hb, 4'hc, 4'hd, 4'h0};
	logic [1:0]  ie [6] = '{2'h2, 2'h0, 2'h2, 2'h3, 2'h2, 2'h0};
	gpm_port #(.PINS(GPM_PINS)) gpm_port_inst (.clk_in(clk_in),
		.reset_in(reset_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.pstrb_in(4'hf), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .pin_level_in(pins), .pad_out(pad),
		.first_alt_in(alt1), .second_alt_in(alt2), .third_alt_in(alt3),
		.timer1_cap_a_out(t1a), .timer1_cap_b_out(t1b),
		.timer2_cap_a_out(t2a), .timer2_cap_b_out(t2b), .irq_out(irq));
	gpm_pin_model gpm_pin_model_inst (.clk_in(clk_in), .pad_in(pad),
		.ext_val_in(ext_val), .ext_en_in(ext_en), .pin_level_out(pins));
	initial begin
		forever #25 clk_in = ~clk_in;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		do @(posedge clk_in); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// pins pass a synchroniser, so reads wait for it to settle
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		repeat (4) @(posedge clk_in);
		xfer(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk_in);
		failures++;
		summarize();
	end
	initial begin
		repeat (10) @(posedge clk_in);
		reset_in <= 1'b0;
		rdc(GPM_OFF_DATA, 32'h2e35);
		for (int i = 0; i < 13; i++) begin
			rdc(ra[i], {16'h0, rv[i]});
		end
		chk({17'h0, pad.pull}, 32'h7fff);
		for (int i = 0; i < 13; i++) begin
			// reserved function bits are written at their reset value
			wv = (ra[i] == GPM_OFF_FNHI) ? GPM_FNHI_MASK : 32'hffff_ffff;
			wv = (ra[i] == GPM_OFF_FNLO) ? GPM_FNLO_MASK : wv;
			xfer(1'b1, ra[i], wv);
			rdc(ra[i], ro[i]);
		end
		for (int i = 0; i < 13; i++) begin
			xfer(1'b1, ra[i], 32'h0);
		end
		xfer(1'b1, GPM_OFF_ICLR, 32'h7fff);
		xfer(1'b0, 12'h048, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("test registers done");
		ext_en <= 15'h7f00;
		xfer(1'b1, GPM_OFF_DIR, 32'hff);
		xfer(1'b1, GPM_OFF_DATA, 32'ha5);
		rdc(GPM_OFF_DATA, 32'h2ca5);
		xfer(1'b1, GPM_OFF_SET, 32'h0a);
		rdc(GPM_OFF_DATA, 32'h2caf);
		xfer(1'b1, GPM_OFF_CLR, 32'h81);
		rdc(GPM_OFF_DATA, 32'h2c2e);
		for (int k = 0; k < 5; k++) begin
			xfer(1'b1, GPM_OFF_FNLO, {25'h0, fc[k], 1'b0, fc[k]});
			repeat (3) @(posedge clk_in);
			chk({28'h0, pad.oe[1:0], pad.out[1:0] & pad.oe[1:0]},
				{28'h0, fx[k]});
		end
		$display("test outputs and functions done");
		xfer(1'b1, GPM_OFF_FNLO, 32'h0);
		xfer(1'b1, GPM_OFF_DIR, 32'h0);
		ext_en <= 15'h7fff;
		for (int m = 0; m < 6; m++) begin
			ext_val[3] <= 1'b1;
			xfer(1'b1, GPM_OFF_SENSE, {28'h0, ic[m][2], 3'h0});
			xfer(1'b1, GPM_OFF_BOTH, {28'h0, ic[m][1], 3'h0});
			xfer(1'b1, GPM_OFF_POL, {28'h0, ic[m][0], 3'h0});
			xfer(1'b1, GPM_OFF_MASK, 32'h0);
			xfer(1'b1, GPM_OFF_ICLR, 32'h8);
			xfer(1'b1, GPM_OFF_MASK, {28'h0, ic[m][3], 3'h0});
			ext_val[3] <= 1'b0;
			rdc(GPM_OFF_MSTAT, {28'h0, ie[m][1], 3'h0});
			chk({31'h0, irq}, {31'h0, ie[m][1]});
			xfer(1'b1, GPM_OFF_ICLR, 32'h8);
			rdc(GPM_OFF_MSTAT, {28'h0, ie[m][0], 3'h0});
		end
		$display("test interrupts done");
		ext_val <= 15'h4021;
		xfer(1'b1, GPM_OFF_ROUTE, 32'h0f0e_0c05);
		repeat (6) @(posedge clk_in);
		chk({28'h0, t1a, t1b, t2a, t2b}, 32'ha);
		xfer(1'b1, GPM_OFF_ROUTE, 32'h0);
		repeat (6) @(posedge clk_in);
		chk({28'h0, t1a, t1b, t2a, t2b}, 32'hf);
		$display("test routing done");
		summarize();
	end
endmodule
